// *** scfmt_pkg.sv ***
// package: register map, field positions, reset values and types of the scalable format csr bank
package scfmt_pkg;
    // fixed pointer words and the csr space they index
    localparam logic [31:0] ADDR_PTR_MODE0  = 32'hF0F002E0;
    localparam logic [31:0] ADDR_PTR_MODE1  = 32'hF0F002E4;
    localparam logic [31:0] CSR_SPACE_BASE  = 32'hF0000000;
    localparam logic [31:0] QUAD_OFS_MODE0  = 32'h003C2000;
    localparam logic [31:0] QUAD_OFS_MODE1  = 32'h003C2400;
    localparam logic [31:0] ADDR_TEMP       = 32'hF0F0082C;
    localparam logic [31:0] ADDR_CTRL       = 32'hF0F00700;
    // offsets inside a mode control block
    localparam logic [11:0] OFS_MAX_SIZE    = 12'h000;
    localparam logic [11:0] OFS_UNIT_SIZE   = 12'h004;
    localparam logic [11:0] OFS_ORIGIN      = 12'h008;
    localparam logic [11:0] OFS_DIMS        = 12'h00C;
    localparam logic [11:0] OFS_PIX_SEL     = 12'h010;
    localparam logic [11:0] OFS_PIX_INQ     = 12'h014;
    localparam logic [11:0] OFS_VPIX_INQ    = 12'h024;
    localparam logic [11:0] OFS_PIX_COUNT   = 12'h034;
    localparam logic [11:0] OFS_BYTES_HI    = 12'h038;
    localparam logic [11:0] OFS_BYTES_LO    = 12'h03C;
    localparam logic [11:0] OFS_PKT_INQ     = 12'h040;
    localparam logic [11:0] OFS_PKT_SIZE    = 12'h044;
    localparam logic [11:0] OFS_SETTING     = 12'h07C;
    // field positions (bit 0 of the map is the word's msb)
    localparam int          PIX_LSB         = 24;
    localparam int          SET_APPLY_BIT   = 30;
    localparam int          FAULT_A_BIT     = 23;
    localparam int          FAULT_B_BIT     = 22;
    localparam int          TEMP_PRESENT_BIT = 31;
    localparam int          TEMP_ABS_BIT    = 30;
    localparam int          TEMP_ONOFF_BIT  = 25;
    localparam int          CTRL_SEL_BIT    = 0;
    localparam int          CTRL_MODE_BIT   = 1;
    localparam int          CTRL_INIT_BIT   = 2;
    localparam int          CTRL_BLOCK_BIT  = 8;
    localparam int          INQ_MONO8_BIT   = 31;
    localparam int          VINQ_MONO12_BIT = 27;
    localparam int          VINQ_RAW12_BIT  = 23;
    // pixel format identifiers and reset defaults
    localparam logic [7:0]  PIX_MONO8       = 8'h00;
    localparam logic [7:0]  PIX_MONO12_PK   = 8'h84;
    localparam logic [7:0]  PIX_RAW12_PK    = 8'h88;
    localparam logic [7:0]  PIX_RST         = PIX_MONO8;
    localparam logic [15:0] ORIGIN_RST      = 16'h0000;
    // temperature scaling and clamp
    localparam int          TEMP_MIN_C      = -55;
    localparam int          TEMP_MAX_C      = 150;
    localparam int          TEMP_STEPS_PER_C = 4;
    localparam int          TEMP_TENTHS_PER_C = 10;
    localparam logic signed [10:0] TEMP_Q_MIN = 11'(TEMP_MIN_C * TEMP_STEPS_PER_C);
    localparam logic signed [10:0] TEMP_Q_MAX = 11'(TEMP_MAX_C * TEMP_STEPS_PER_C);
    localparam logic signed [11:0] TEMP_T_MIN = 12'(TEMP_MIN_C * TEMP_TENTHS_PER_C);
    localparam logic signed [11:0] TEMP_T_MAX = 12'(TEMP_MAX_C * TEMP_TENTHS_PER_C);

    typedef struct packed {
        logic [15:0] left;
        logic [15:0] top;
        logic [15:0] width;
        logic [15:0] height;
        logic [7:0]  pix;
        logic [15:0] bpp;
    } scfmt_mode_t;

    typedef enum logic [1:0] {
        SCF_IDLE = 2'b01,
        SCF_DATA = 2'b10
    } scfmt_bus_t;

    function automatic logic [31:0] quad_to_base(input logic [31:0] q);
        return CSR_SPACE_BASE + {q[29:0], 2'b00};
    endfunction
endpackage

// *** scfmt_csr.sv ***
// module: ahb-lite register bank for two scalable video modes and the sensor temperature word
`timescale 1ns/1ps

// What this block does
// - the word at the first pointer address gives mode zero's quadlet offset, and its block sits at the csr base plus four times it.
// - the next pointer word gives mode one's quadlet offset, with its block base found the same way.
// - any access to a mode's control block recomputes both of that mode's configuration fault flags.
// - every access to a mode block refreshes its derived registers, and every access but a write of the apply bit clears that mode's settings-apply bit.
// - while the scalable format is selected and a fault flag of the active mode is set, no capture is started.
// - an init command or a reset loads the pixel format selection of every mode with its default.
// - the packet unit-bytes field of the packet parameter inquiry reads as a fixed constant.
// - vendor pixel formats use ids 128 to 255, with 132 packed 12-bit mono, 136 packed 12-bit raw and 133 to 135 reserved.
// - the temperature word's msb (map bit 0) reads one to show the feature is present.
// - map bit 1 of the temperature word selects absolute control, and then the value field is ignored.
// - the on/off bit (map bit 6) always reads one, and map bits 2-5 and 7-19 are reserved.
// - map bits 20-31 report the sensor temperature in tenths of a degree, read only.
// - the reported temperature is clamped to -55..150 degrees and moves in quarter-degree steps.
module scfmt_csr
    import scfmt_pkg::*;
#(
    parameter logic [15:0] MAX_W    = 16'h0400,
    parameter logic [15:0] MAX_H    = 16'h0300,
    parameter logic [15:0] UNIT_H   = 16'h0004,
    parameter logic [15:0] UNIT_V   = 16'h0002,
    parameter logic [15:0] UNIT_BPP = 16'h0004,
    parameter logic [15:0] MAX_BPP  = 16'h1000
)
(
    input  wire logic               hclk,            // bus clock
    input  wire logic               hresetn,         // async reset, low active
    input  wire logic               ce,              // clock enable, low freezes all state
    input  wire logic               hsel,            // slave select
    input  wire logic [31:0]        haddr,           // byte address
    input  wire logic [1:0]         htrans,          // transfer type
    input  wire logic               hwrite,          // write when high
    input  wire logic [2:0]         hsize,           // word only
    input  wire logic [31:0]        hwdata,          // write data
    input  wire logic               hready,          // bus ready
    output logic      [31:0]        hrdata,          // read data
    output logic                    hreadyout,       // slave ready
    output logic                    hresp,           // always okay
    input  wire logic signed [10:0] sensor_temp_q,   // sensor in quarter degrees
    input  wire logic               capture_req,     // capture request pulse
    output logic                    capture_start,   // capture start pulse
    output logic                    capture_blocked, // capture held off by faults
    output logic                    setting_apply    // settings applied pulse
);

    generate
        if (UNIT_H == 16'h0000 || (UNIT_H & (UNIT_H - 16'h0001)) != 16'h0000 ||
            UNIT_V == 16'h0000 || (UNIT_V & (UNIT_V - 16'h0001)) != 16'h0000 ||
            UNIT_BPP == 16'h0000 || (UNIT_BPP & (UNIT_BPP - 16'h0001)) != 16'h0000 ||
            MAX_W == 16'h0000 || MAX_H == 16'h0000 || MAX_BPP < UNIT_BPP)
        begin : g_bad_param
            $error("scfmt_csr: unit sizes must be powers of two and maxima non-zero");
        end
    endgenerate
    localparam logic [31:0] BASE_MODE0 = quad_to_base(QUAD_OFS_MODE0);
    localparam logic [31:0] BASE_MODE1 = quad_to_base(QUAD_OFS_MODE1);
    scfmt_bus_t  state_ff;
    logic [31:0] addr_ff;
    logic        write_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;
    scfmt_mode_t cfg_ff [2];
    scfmt_mode_t nxt_cfg [2];
    logic [1:0]  fault_a_ff;
    logic [1:0]  fault_b_ff;
    logic [1:0]  setting_ff;
    logic        sel_ff;
    logic        mode_ff;
    logic        temp_abs_ff;
    logic [11:0] temp_val_ff;
    logic        capture_start_ff;
    logic        capture_blocked_ff;
    logic        setting_apply_ff;
    logic [31:0] rd;
    logic [1:0]  hit;
    logic        data_ph;
    logic        accept;
    logic        init_cmd;
    logic        blocked;
    logic [11:0] ofs;
    function automatic logic blk_hit(input logic [31:0] a, input logic [31:0] base);
        return a[31:12] == base[31:12];
    endfunction
    function automatic logic pix_ok(input logic [7:0] p);
        return p == PIX_MONO8 || p == PIX_MONO12_PK || p == PIX_RAW12_PK;
    endfunction
    function automatic logic chk_a(input scfmt_mode_t c);
        logic [16:0] right;
        logic [16:0] bottom;
        right  = {1'b0, c.left} + {1'b0, c.width};
        bottom = {1'b0, c.top} + {1'b0, c.height};
        return !pix_ok(c.pix) || c.width == 16'h0000 || c.height == 16'h0000 ||
               right > {1'b0, MAX_W} || bottom > {1'b0, MAX_H} ||
               ((c.width | c.left) & (UNIT_H - 16'h0001)) != 16'h0000 ||
               ((c.height | c.top) & (UNIT_V - 16'h0001)) != 16'h0000;
    endfunction
    function automatic logic chk_b(input scfmt_mode_t c);
        return c.bpp == 16'h0000 || c.bpp > MAX_BPP ||
               (c.bpp & (UNIT_BPP - 16'h0001)) != 16'h0000;
    endfunction
    function automatic logic [32:0] frame_bytes(input scfmt_mode_t c);
        logic [32:0] n;
        // widen before multiplying, a 16-bit product would lose the upper half
        n = {1'b0, 32'(c.width) * 32'(c.height)};
        // packed 12-bit formats carry three bytes per two pixels
        n = (c.pix == PIX_MONO12_PK || c.pix == PIX_RAW12_PK) ? n + {1'b0, n[32:1]} : n;
        return n;
    endfunction
    assign hit[0]   = blk_hit(addr_ff, BASE_MODE0);
    assign hit[1]   = blk_hit(addr_ff, BASE_MODE1);
    assign ofs      = addr_ff[11:0];
    assign data_ph  = state_ff == SCF_DATA;
    assign accept   = state_ff == SCF_IDLE && hsel && htrans[1] && hready;
    assign init_cmd = data_ph && write_ff && addr_ff == ADDR_CTRL && hwdata[CTRL_INIT_BIT];
    assign blocked  = sel_ff && (fault_a_ff[mode_ff] || fault_b_ff[mode_ff]);

    // bus handshake: one wait state so read data can come from a flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff     <= SCF_IDLE;
            addr_ff      <= 32'h00000000;
            write_ff     <= 1'b0;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h00000000;
        end
        else if (ce)
        begin
            case (state_ff)
                SCF_IDLE:
                begin
                    if (accept)
                    begin
                        state_ff     <= SCF_DATA;
                        addr_ff      <= haddr;
                        write_ff     <= hwrite;
                        hreadyout_ff <= 1'b0;
                    end
                end
                SCF_DATA:
                begin
                    state_ff     <= SCF_IDLE;
                    hreadyout_ff <= 1'b1;
                    hrdata_ff    <= write_ff ? 32'h00000000 : rd;
                end
                default:
                begin
                    state_ff     <= SCF_IDLE;
                    hreadyout_ff <= 1'b1;
                end
            endcase
        end
    end

    // next configuration of each mode, writable fields only
    always_comb
    begin
        for (int m = 0; m < 2; m++)
        begin
            nxt_cfg[m] = cfg_ff[m];
            if (data_ph && write_ff && hit[m])
            begin
                case (ofs)
                    OFS_ORIGIN:
                    begin
                        nxt_cfg[m].left = hwdata[31:16];
                        nxt_cfg[m].top  = hwdata[15:0];
                    end
                    OFS_DIMS:
                    begin
                        nxt_cfg[m].width  = hwdata[31:16];
                        nxt_cfg[m].height = hwdata[15:0];
                    end
                    OFS_PIX_SEL:  nxt_cfg[m].pix = hwdata[PIX_LSB +: 8];
                    OFS_PKT_SIZE: nxt_cfg[m].bpp = hwdata[31:16];
                    default:      nxt_cfg[m].bpp = cfg_ff[m].bpp;
                endcase
            end
            if (init_cmd)
            begin
                nxt_cfg[m].pix = PIX_RST;
            end
        end
    end

    // mode configuration, fault flags and settings-apply bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int m = 0; m < 2; m++)
            begin
                cfg_ff[m] <= '{left: ORIGIN_RST, top: ORIGIN_RST, width: MAX_W, height: MAX_H,
                               pix: PIX_RST, bpp: MAX_BPP};
            end
            fault_a_ff <= 2'b00;
            fault_b_ff <= 2'b00;
            setting_ff <= 2'b00;
        end
        else if (ce)
        begin
            for (int m = 0; m < 2; m++)
            begin
                cfg_ff[m] <= nxt_cfg[m];
                if (data_ph && hit[m])
                begin
                    fault_a_ff[m] <= chk_a(nxt_cfg[m]);
                    fault_b_ff[m] <= chk_b(nxt_cfg[m]);
                    // apply bit lives until the next access
                    setting_ff[m] <= write_ff && ofs == OFS_SETTING && hwdata[SET_APPLY_BIT];
                end
            end
        end
    end

    // own control word: format select, active mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_ff  <= 1'b0;
            mode_ff <= 1'b0;
        end
        else if (ce && data_ph && write_ff && addr_ff == ADDR_CTRL)
        begin
            sel_ff  <= hwdata[CTRL_SEL_BIT];
            mode_ff <= hwdata[CTRL_MODE_BIT];
        end
    end

    // temperature: only the absolute-control bit is writable
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            temp_abs_ff <= 1'b0;
        end
        // value field of a write is ignored
        else if (ce && data_ph && write_ff && addr_ff == ADDR_TEMP)
        begin
            temp_abs_ff <= hwdata[TEMP_ABS_BIT];
        end
    end

    // sample, clamp and convert quarter degrees to tenths
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            temp_val_ff <= 12'h000;
        end
        else if (ce)
        begin
            temp_val_ff <= to_tenths(sensor_temp_q);
        end
    end
    function automatic logic [11:0] to_tenths(input logic signed [10:0] q);
        logic signed [10:0] qc;
        logic signed [13:0] prod;
        qc = q < TEMP_Q_MIN ? TEMP_Q_MIN : (q > TEMP_Q_MAX ? TEMP_Q_MAX : q);
        // quarter steps scaled to tenths, fractions truncated
        prod = 14'(qc) * 14'sh000A;
        return 12'(prod >>> 2);
    endfunction
    // read multiplexer; derived inquiries are recomputed on every read
    always_comb
    begin
        scfmt_mode_t c;
        logic [32:0] fb;
        c  = hit[1] ? cfg_ff[1] : cfg_ff[0];
        fb = frame_bytes(c);
        rd = 32'h00000000;
        if (addr_ff == ADDR_PTR_MODE0)
        begin
            rd = QUAD_OFS_MODE0;
        end
        else if (addr_ff == ADDR_PTR_MODE1)
        begin
            rd = QUAD_OFS_MODE1;
        end
        else if (addr_ff == ADDR_TEMP)
        begin
            rd[TEMP_PRESENT_BIT] = 1'b1;
            rd[TEMP_ABS_BIT]     = temp_abs_ff;
            rd[TEMP_ONOFF_BIT]   = 1'b1;
            rd[11:0]             = temp_val_ff;
        end
        else if (addr_ff == ADDR_CTRL)
        begin
            rd[CTRL_SEL_BIT]   = sel_ff;
            rd[CTRL_MODE_BIT]  = mode_ff;
            rd[CTRL_BLOCK_BIT] = blocked;
        end
        else if (hit != 2'b00)
        begin
            case (ofs)
                OFS_MAX_SIZE:  rd = {MAX_W, MAX_H};
                OFS_UNIT_SIZE: rd = {UNIT_H, UNIT_V};
                OFS_ORIGIN:    rd = {c.left, c.top};
                OFS_DIMS:      rd = {c.width, c.height};
                OFS_PIX_SEL:   rd[PIX_LSB +: 8] = c.pix;
                OFS_PIX_INQ:   rd[INQ_MONO8_BIT] = 1'b1;
                OFS_VPIX_INQ:
                begin
                    // only 132 and 136 of the vendor range exist
                    rd[VINQ_MONO12_BIT] = 1'b1;
                    rd[VINQ_RAW12_BIT]  = 1'b1;
                end
                OFS_PIX_COUNT: rd = 32'(c.width) * 32'(c.height);
                OFS_BYTES_HI:  rd = {31'h00000000, fb[32]};
                OFS_BYTES_LO:  rd = fb[31:0];
                OFS_PKT_INQ:   rd = {UNIT_BPP, MAX_BPP};
                OFS_PKT_SIZE:  rd = {c.bpp, c.bpp};
                OFS_SETTING:
                begin
                    rd[SET_APPLY_BIT] = hit[1] ? setting_ff[1] : setting_ff[0];
                    rd[FAULT_A_BIT]   = hit[1] ? fault_a_ff[1] : fault_a_ff[0];
                    rd[FAULT_B_BIT]   = hit[1] ? fault_b_ff[1] : fault_b_ff[0];
                end
                default:       rd = 32'h00000000;
            endcase
        end
    end

    // capture gate and apply pulse
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            capture_start_ff   <= 1'b0;
            capture_blocked_ff <= 1'b0;
            setting_apply_ff   <= 1'b0;
        end
        else if (ce)
        begin
            capture_start_ff   <= capture_req && !blocked;
            capture_blocked_ff <= blocked;
            setting_apply_ff   <= data_ph && write_ff && hit != 2'b00 && ofs == OFS_SETTING &&
                                  hwdata[SET_APPLY_BIT];
        end
    end

    assign hrdata          = hrdata_ff;
    assign hreadyout       = hreadyout_ff;
    assign hresp           = 1'b0;
    assign capture_start   = capture_start_ff;
    assign capture_blocked = capture_blocked_ff;
    assign setting_apply   = setting_apply_ff;
    a_ptr_mode0_read: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (data_ph && !write_ff && addr_ff == ADDR_PTR_MODE0) |=> (hreadyout && hrdata == 32'h003C2000))
        else $error("mode zero pointer read wrong");
    a_ptr_mode1_read: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (accept && !hwrite && haddr == ADDR_PTR_MODE1) |=> ##1 (hreadyout && hrdata == 32'h003C2400))
        else $error("mode one pointer read wrong");
    a_fault_refresh: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (data_ph && write_ff && hit[0] && ofs == OFS_DIMS && hwdata[31:16] == 16'h0000) |=> fault_a_ff[0])
        else $error("fault flag not refreshed on zero width");
    a_setting_clear: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (data_ph && hit[0] && !(write_ff && ofs == OFS_SETTING)) |=> !setting_ff[0])
        else $error("settings-apply bit not cleared by access");
    a_capture_refused: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (capture_req && sel_ff && (fault_a_ff[mode_ff] || fault_b_ff[mode_ff])) |=> !capture_start)
        else $error("capture started while faulted");
    a_init_default: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        init_cmd |=> (cfg_ff[0].pix == PIX_RST && cfg_ff[1].pix == PIX_RST))
        else $error("init did not restore pixel format");
    a_unit_bytes: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (data_ph && !write_ff && hit[0] && ofs == OFS_PKT_INQ) |=> hrdata[31:16] == UNIT_BPP)
        else $error("packet unit bytes not fixed");
    a_temp_fixed_bits: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (data_ph && !write_ff && addr_ff == ADDR_TEMP) |=> (hrdata[31] && hrdata[25] && hrdata[24:12] == 13'h0000))
        else $error("temperature fixed bits wrong");
    a_temp_clamped: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        $signed(temp_val_ff) >= TEMP_T_MIN && $signed(temp_val_ff) <= TEMP_T_MAX)
        else $error("temperature outside clamp");
    a_ro_ignored: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
        (data_ph && write_ff && hit[0] && ofs == OFS_MAX_SIZE) |=> $stable(cfg_ff[0]))
        else $error("inquiry write changed configuration");
endmodule

// *** scfmt_tb.sv ***
// self-checking testbench for the scalable format csr bank
`timescale 1ns/1ps
module testbench;
    import scfmt_pkg::*;
    localparam logic [31:0] B0 = 32'hF0000000 + (32'h003C2000 << 2);
    localparam logic [31:0] B1 = 32'hF0000000 + (32'h003C2400 << 2);
    logic               hclk          = 1'b0;
    logic               hresetn       = 1'b0;
    logic               hsel          = 1'b0;
    logic [31:0]        haddr         = 32'h0;
    logic [1:0]         htrans        = 2'h0;
    logic               hwrite        = 1'b0;
    logic [31:0]        hwdata        = 32'h0;
    logic signed [10:0] sensor_temp_q = 11'h0;
    logic               capture_req   = 1'b0;
    logic [31:0]        seed          = 32'h0000005E;
    logic signed [10:0] v;
    logic               ab            = 1'b0;
    logic               rd_ph         = 1'b0;
    logic [31:0]        exp_q[$];
    wire logic [31:0]   hrdata;
    wire logic          hreadyout, hresp, capture_start, capture_blocked, setting_apply;
    int                 n_errors = 0, checks = 0, n_apply = 0, q;

    always #20 hclk = ~hclk;

    scfmt_csr dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sensor_temp_q(sensor_temp_q), .capture_req(capture_req),
        .capture_start(capture_start), .capture_blocked(capture_blocked), .setting_apply(setting_apply));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one word transfer; each phase is held until hready is sampled high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic cap(input logic e);
        capture_req <= 1'b1;
        @(posedge hclk);
        capture_req <= 1'b0;
        #1 check("capture_start", {31'h0, capture_start}, {31'h0, e});
        @(posedge hclk);
    endtask

    // read data is compared when the data phase of a read completes
    always @(posedge hclk)
    begin
        if (setting_apply === 1'b1)
            n_apply++;
        if (rd_ph && hreadyout === 1'b1)
        begin
            rd_ph <= 1'b0;
            check("hrdata", hrdata, exp_q.pop_front());
            check("hresp", {31'h0, hresp}, 32'h0);
        end
        else if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1)
            rd_ph <= 1'b1;
    end

    initial
    begin
        #(40 * 20000);
        n_errors++;
        conclude();
    end

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADDR_PTR_MODE0, 32'h003C2000);
        rd(ADDR_PTR_MODE1, 32'h003C2400);
        rd(B0 + OFS_UNIT_SIZE, 32'h00040002);
        rd(B0 + OFS_PIX_INQ, 32'h80000000);
        rd(B0 + OFS_PIX_COUNT, 32'h000C0000);
        rd(B0 + OFS_BYTES_HI, 32'h0);
        rd(B0 + OFS_BYTES_LO, 32'h000C0000);
        rd(B0 + OFS_PIX_SEL, 32'h0);
        rd(B0 + OFS_PKT_INQ, {16'h0004, 16'h1000});
        rd(B0 + OFS_VPIX_INQ, 32'h08800000);
        wr(B0 + OFS_MAX_SIZE, 32'hFFFFFFFF);
        rd(B0 + OFS_MAX_SIZE, 32'h04000300);
        wr(32'hF0F00000, 32'hFFFFFFFF);
        rd(32'hF0F00000, 32'h0);
        // vendor formats, then init restores default
        wr(B0 + OFS_PIX_SEL, 32'h84000000);
        wr(B1 + OFS_PIX_SEL, 32'h88000000);
        rd(B0 + OFS_PIX_SEL, 32'h84000000);
        rd(B0 + OFS_BYTES_LO, 32'h00120000);
        rd(B1 + OFS_PIX_SEL, 32'h88000000);
        wr(ADDR_CTRL, 32'h00000004);
        rd(B0 + OFS_PIX_SEL, 32'h0);
        rd(B1 + OFS_PIX_SEL, 32'h0);
        // misaligned origin sets fault a and holds off capture
        wr(B0 + OFS_ORIGIN, 32'h00010000);
        rd(B0 + OFS_SETTING, 32'h00800000);
        wr(ADDR_CTRL, 32'h00000001);
        repeat (2) @(posedge hclk);
        check("capture_blocked", {31'h0, capture_blocked}, 32'h1);
        rd(ADDR_CTRL, 32'h00000101);
        cap(1'b0);
        wr(B0 + OFS_ORIGIN, 32'h0);
        repeat (2) @(posedge hclk);
        cap(1'b1);
        // apply pulse only for a write of the apply bit
        wr(B0 + OFS_SETTING, 32'h40000000);
        rd(B0 + OFS_SETTING, 32'h40000000);
        rd(B0 + OFS_SETTING, 32'h0);
        wr(B0 + OFS_SETTING, 32'h0);
        repeat (3) @(posedge hclk);
        check("setting_apply pulses", 32'(n_apply), 32'h1);
        // packet size off the unit sets fault b of mode one
        wr(B1 + OFS_PKT_SIZE, 32'h00030000);
        rd(B1 + OFS_PKT_SIZE, 32'h00030003);
        rd(B1 + OFS_SETTING, 32'h00400000);
        wr(B0 + OFS_DIMS, 32'h00000300);
        rd(B0 + OFS_PIX_COUNT, 32'h0);
        rd(B0 + OFS_SETTING, 32'h00800000);
        // temperature word, extremes then random values
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            v = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : seed[10:0];
            sensor_temp_q <= v;
            q = v;
            q = (q < -220) ? -220 : (q > 600) ? 600 : q;
            if (i == 4)
            begin
                wr(ADDR_TEMP, 32'hFFFFFFFF);
                ab = 1'b1;
            end
            repeat (3) @(posedge hclk);
            rd(ADDR_TEMP, {1'b1, ab, 4'h0, 1'b1, 13'h0, 12'((q * 10) >>> 2)});
        end
        conclude();
    end
endmodule
